// ==== common/srh_pkg.sv ====
package srh_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // ==========================================================
  // Command cycle addresses and data
  localparam logic [23:0] UNLOCK1_ADDR = 24'h000555;
  localparam logic [23:0] UNLOCK2_ADDR = 24'h0002AA;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] ENTRY_DATA   = 16'h0088;
  localparam logic [15:0] EXIT_DATA    = 16'h0090;
  localparam logic [15:0] EXIT_TAIL    = 16'h0000;
  localparam logic [15:0] PROG_DATA    = 16'h00A0;

  // ==========================================================
  // Secure region geometry
  localparam logic [23:0] REGION_WORDS = 24'h000080;
  localparam logic [23:0] SERIAL_LAST  = 24'h000007;
  localparam logic [23:0] SECTOR_MASK  = 24'hFF0000;

  // ==========================================================
  // Bus timing: write strobe low and high widths, read access time
  localparam int CLK_NS     = 8;
  localparam int WE_LOW_NS  = 40;
  localparam int WE_HIGH_NS = 24;
  localparam int RD_NS      = 112;
  localparam int WE_LOW_CYC  = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC      = (RD_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Host operations
  typedef enum logic [1:0] {
    SRH_OP_ENTER = 2'h0,
    SRH_OP_EXIT  = 2'h1,
    SRH_OP_PROG  = 2'h2,
    SRH_OP_READ  = 2'h3
  } srh_op_t;

  // Request from user side
  typedef struct packed {
    srh_op_t            op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } srh_req_t;

  // Pins toward the flash
  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  dq_out;
    logic               dq_oe;
    logic               ce_n;
    logic               oe_n;
    logic               we_n;
  } srh_pins_t;

endpackage

// ==== design/srh_host.sv ====
// How it works
// RL1 - Factory-locked part reports lock bit 1
// RL2 - Customer-lockable part ships unlocked, bit 0
// RL3 - Customer-locked part holds lock bit 0
// RL4 - Region programs once, reads unlimited
// RL5 - No unlock command once locked
// RL6 - Accelerate and bypass barred in mode
// RL7 - Host issues exit after lock and verify
// RL8 - Entry: AA@555, 55@2AA, 88@555
// RL9 - Exit: AA, 55, 90@555, then 00
// RL10 - Mode remaps first sector to region
// RL11 - Only exit or power loss ends mode; reset also clears it here
// RL12 - Program: AA, 55, A0@555, data@target
// RL13 - Serial number at region words 0-7
// RL14 - Mode reads both areas, programs customer
// RL15 - Reset returns device to normal array
// RL16 - Region is 128 words; beyond invalid
// RL17 - No region access during embedded ops
// RL18 - Outside first sector reads normal array
module srh_host (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire srh_pkg::srh_req_t req_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              flash_busy_i,
  input  wire logic [15:0]       dq_i,
  output srh_pkg::srh_pins_t     pins_o,
  output logic [15:0]            rd_data_o,
  output logic                   rd_valid_o,
  output logic                   rd_invalid_o,
  output logic                   req_err_o,
  output logic                   mode_o
);

  // ==========================================================
  // Sequencer states
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_WLOW  = 5'h02,
    S_WHIGH = 5'h04,
    S_READ  = 5'h08,
    S_DONE  = 5'h10
  } srh_state_t;

  srh_state_t          state_q, state_d;
  srh_pkg::srh_req_t   cur_q, cur_d;
  logic [2:0]          step_q, step_d;
  logic [4:0]          cnt_q, cnt_d;
  logic                mode_q, mode_d;
  srh_pkg::srh_pins_t  pins_q, pins_d;
  logic [15:0]         rdat_q, rdat_d;
  logic                rval_q, rval_d;
  logic                rinv_q, rinv_d;
  logic                err_q, err_d;
  logic [2:0]          nsteps;
  logic [23:0]         cyc_addr;
  logic [15:0]         cyc_data;
  logic                bad_req;

  // Number of write cycles for an operation
  function automatic logic [2:0] op_steps(input srh_pkg::srh_op_t op);
    unique case (op)
      srh_pkg::SRH_OP_ENTER: op_steps = 3'h3; // see RL8
      srh_pkg::SRH_OP_EXIT:  op_steps = 3'h4; // see RL9
      srh_pkg::SRH_OP_PROG:  op_steps = 3'h4; // see RL12
      srh_pkg::SRH_OP_READ:  op_steps = 3'h0; // see RL4 RL5 RL6
    endcase
  endfunction

  // Address and data for one write cycle
  always_comb begin
    cyc_addr = srh_pkg::UNLOCK1_ADDR;
    cyc_data = srh_pkg::UNLOCK1_DATA;
    unique case (step_q)
      3'h0: begin
        cyc_addr = srh_pkg::UNLOCK1_ADDR;
        cyc_data = srh_pkg::UNLOCK1_DATA;
      end
      3'h1: begin
        cyc_addr = srh_pkg::UNLOCK2_ADDR;
        cyc_data = srh_pkg::UNLOCK2_DATA;
      end
      3'h2: begin
        cyc_addr = srh_pkg::UNLOCK1_ADDR;
        unique case (cur_q.op)
          srh_pkg::SRH_OP_ENTER: cyc_data = srh_pkg::ENTRY_DATA; // see RL8
          srh_pkg::SRH_OP_EXIT:  cyc_data = srh_pkg::EXIT_DATA;  // see RL9
          default:               cyc_data = srh_pkg::PROG_DATA;  // see RL12
        endcase
      end
      default: begin
        cyc_addr = cur_q.addr;
        cyc_data = (cur_q.op == srh_pkg::SRH_OP_EXIT) ? srh_pkg::EXIT_TAIL : cur_q.data; // see RL9
      end
    endcase
  end

  // Refuse ops the mode forbids or a busy flash cannot serve
  always_comb begin
    bad_req = 1'b0;
    if (flash_busy_i) begin
      bad_req = 1'b1; // see RL17
    end else if (req_i.op == srh_pkg::SRH_OP_ENTER && mode_q) begin
      bad_req = 1'b1;
    end else if (req_i.op == srh_pkg::SRH_OP_EXIT && !mode_q) begin
      bad_req = 1'b1;
    end else if (req_i.op == srh_pkg::SRH_OP_PROG &&
                 (!mode_q || req_i.addr >= srh_pkg::REGION_WORDS ||
                  req_i.addr <= srh_pkg::SERIAL_LAST)) begin
      bad_req = 1'b1; // see RL13 RL14
    end
  end

  assign req_ready_o = (state_q == S_IDLE);
  assign nsteps      = op_steps(cur_q.op);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cur_d   = cur_q;
    step_d  = step_q;
    cnt_d   = cnt_q;
    mode_d  = mode_q;
    pins_d  = pins_q;
    rdat_d  = rdat_q;
    rval_d  = 1'b0;
    rinv_d  = rinv_q;
    err_d   = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        pins_d.ce_n  = 1'b1;
        pins_d.oe_n  = 1'b1;
        pins_d.we_n  = 1'b1;
        pins_d.dq_oe = 1'b0;
        if (req_valid_i) begin
          if (bad_req) begin
            err_d = 1'b1;
          end else begin
            cur_d  = req_i;
            step_d = 3'h0;
            cnt_d  = 5'h00;
            if (req_i.op == srh_pkg::SRH_OP_READ) begin
              pins_d.addr = req_i.addr; // see RL10 RL18
              pins_d.ce_n = 1'b0;
              pins_d.oe_n = 1'b0;
              state_d     = S_READ;
            end else begin
              state_d = S_WLOW;
            end
          end
        end
      end
      S_WLOW: begin
        pins_d.addr   = cyc_addr;
        pins_d.dq_out = cyc_data;
        pins_d.dq_oe  = 1'b1;
        pins_d.ce_n   = 1'b0;
        pins_d.we_n   = 1'b0;
        cnt_d         = cnt_q + 5'h01;
        if (cnt_q == 5'(srh_pkg::WE_LOW_CYC - 1)) begin
          cnt_d   = 5'h00;
          state_d = S_WHIGH;
        end
      end
      S_WHIGH: begin
        pins_d.we_n = 1'b1;
        cnt_d       = cnt_q + 5'h01;
        if (cnt_q == 5'(srh_pkg::WE_HIGH_CYC - 1)) begin
          cnt_d  = 5'h00;
          step_d = step_q + 3'h1;
          if (step_q + 3'h1 == nsteps) begin
            state_d = S_DONE;
            if (cur_q.op == srh_pkg::SRH_OP_ENTER) mode_d = 1'b1; // see RL8
            if (cur_q.op == srh_pkg::SRH_OP_EXIT)  mode_d = 1'b0; // see RL7 RL11
          end else begin
            state_d = S_WLOW;
          end
        end
      end
      S_READ: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == 5'(srh_pkg::RD_CYC - 1)) begin
          rdat_d = dq_i; // see RL1 RL2 RL3
          rval_d = 1'b1;
          // Remapped sector beyond region is invalid
          rinv_d = mode_q && ((cur_q.addr & srh_pkg::SECTOR_MASK) == 24'h000000)
                   && (cur_q.addr >= srh_pkg::REGION_WORDS); // see RL16
          state_d = S_DONE;
        end
      end
      S_DONE: begin
        pins_d.ce_n  = 1'b1;
        pins_d.oe_n  = 1'b1;
        pins_d.dq_oe = 1'b0;
        state_d      = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Sequencer registers; reset clears mode as device does
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= S_IDLE;
      cur_q   <= '0;
      step_q  <= 3'h0;
      cnt_q   <= 5'h00;
      mode_q  <= 1'b0; // see RL15
      pins_q  <= '{addr: 24'h000000, dq_out: 16'h0000, dq_oe: 1'b0,
                   ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      rdat_q  <= 16'h0000;
      rval_q  <= 1'b0;
      rinv_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      step_q  <= step_d;
      cnt_q   <= cnt_d;
      mode_q  <= mode_d;
      pins_q  <= pins_d;
      rdat_q  <= rdat_d;
      rval_q  <= rval_d;
      rinv_q  <= rinv_d;
      err_q   <= err_d;
    end
  end

  assign pins_o       = pins_q;
  assign rd_data_o    = rdat_q;
  assign rd_valid_o   = rval_q;
  assign rd_invalid_o = rinv_q;
  assign req_err_o    = err_q;
  assign mode_o       = mode_q;

  // ==========================================================
  // Checks
  property p_we_width;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(pins_q.we_n) |-> !pins_q.we_n [*5];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short"); // see RL8

  property p_enter_mode;
    @(posedge sys_clk_i) disable iff (reset_i)
    $rose(mode_q) |-> $past(cur_q.op) == srh_pkg::SRH_OP_ENTER && $past(step_q) == 3'h2;
  endproperty
  a_enter_mode: assert property (p_enter_mode) else $error("mode set without entry"); // see RL8

  property p_exit_mode;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(mode_q) |-> $past(cur_q.op) == srh_pkg::SRH_OP_EXIT && $past(step_q) == 3'h3;
  endproperty
  a_exit_mode: assert property (p_exit_mode) else $error("mode cleared without exit"); // see RL9

  property p_exit_tail;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(pins_q.we_n) && cur_q.op == srh_pkg::SRH_OP_EXIT && step_q == 3'h3
      |-> pins_q.dq_out == srh_pkg::EXIT_TAIL;
  endproperty
  a_exit_tail: assert property (p_exit_tail) else $error("exit tail not zero"); // see RL9

  property p_prog_cmd;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(pins_q.we_n) && cur_q.op == srh_pkg::SRH_OP_PROG && step_q == 3'h2
      |-> pins_q.dq_out == srh_pkg::PROG_DATA && pins_q.addr == srh_pkg::UNLOCK1_ADDR;
  endproperty
  a_prog_cmd: assert property (p_prog_cmd) else $error("program setup wrong"); // see RL12

  property p_prog_customer;
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == S_WLOW && cur_q.op == srh_pkg::SRH_OP_PROG |-> mode_q && cur_q.addr > srh_pkg::SERIAL_LAST;
  endproperty
  a_prog_customer: assert property (p_prog_customer) else $error("program outside customer area"); // see RL14

  property p_busy_refused;
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == S_IDLE && req_valid_i && flash_busy_i |=> err_q && state_q == S_IDLE;
  endproperty
  a_busy_refused: assert property (p_busy_refused) else $error("request taken while busy"); // see RL17

  property p_read_time;
    @(posedge sys_clk_i) disable iff (reset_i)
    $rose(state_q == S_READ) |-> ##14 rval_q;
  endproperty
  a_read_time: assert property (p_read_time) else $error("read answer late"); // see RL10

endmodule

// ==== verification/srh_flash_model.sv ====
module srh_flash_model (
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  input  wire srh_pkg::srh_pins_t pins_i,
  output logic [15:0]             dq_o,
  output logic                    busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] region [128];
  logic [2:0]  step_q;
  logic        mode_q;
  logic [15:0] last_q;
  logic [15:0] rd;
  logic [23:0] a;
  logic [15:0] d;
  logic        s0;

  // ==========================================================
  // Serial words then blank customer area, unlocked part
  initial begin
    for (int i = 0; i < 128; i++) begin
      region[i] = (i < 8) ? 16'hE500 + 16'(i) : 16'hFFFF;
    end
    busy_o = 1'b0;
    last_q = 16'h0000;
  end

  assign a  = pins_i.addr;
  assign d  = pins_i.dq_out;
  assign s0 = (a[23:16] == 8'h00);

  // ==========================================================
  // Command decoder; no unlock, accelerate or bypass path exists
  always @(posedge pins_i.we_n or posedge reset_i) begin
    if (reset_i) begin
      step_q = 3'h0;
      mode_q = 1'b0;
    end else if (!pins_i.ce_n) begin
      case (step_q)
        3'h0: step_q = (d == 16'h00AA && a == 24'h000555) ? 3'h1 : 3'h0;
        3'h1: step_q = (d == 16'h0055 && a == 24'h0002AA) ? 3'h2 : 3'h0;
        3'h2: begin
          step_q = 3'h0;
          if (a == 24'h000555 && d == 16'h0088) mode_q = 1'b1;
          if (a == 24'h000555 && d == 16'h0090 && mode_q) step_q = 3'h3;
          if (a == 24'h000555 && d == 16'h00A0) step_q = 3'h4;
        end
        3'h3: begin
          if (d == 16'h0000) mode_q = 1'b0;
          step_q = 3'h0;
        end
        default: begin
          // Program clears bits only, customer area only
          if (mode_q && s0 && a >= 24'h8 && a < 24'h80) region[a[6:0]] &= d;
          fork
            begin
              busy_o = 1'b1;
              #200 busy_o = 1'b0;
            end
          join_none
          step_q = 3'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // Read path with sector remap, released bus shows inverse
  always_comb begin
    rd = (mode_q && s0) ? ((a < 24'h80) ? region[a[6:0]] : 16'hDEAD) : (a[15:0] ^ 16'h3C3C);
    dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? rd : ~last_q;
  end

  always @(posedge sys_clk_i) begin
    if (!pins_i.ce_n && !pins_i.oe_n) last_q <= rd;
  end
endmodule

// ==== verification/srh_host_tb.sv ====
module srh_host_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               sys_clk_i = 1'b0;
  logic               reset_i = 1'b1;
  logic               req_valid_i = 1'b0;
  srh_pkg::srh_req_t  req_i = '0;
  srh_pkg::srh_pins_t pins;
  logic [15:0]        dq;
  logic [15:0]        rd_data;
  logic               busy, ready, rd_valid, rd_inv, err, mode;
  int                 n_errors = 0;
  int                 samples_checked = 0;
  int                 n;
  logic [17:0]        expq [$];
  logic [17:0]        e;
  logic [23:0]        pa;
  logic [15:0]        pd;

  always #4 sys_clk_i = ~sys_clk_i;

  srh_host i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(ready), .flash_busy_i(busy), .dq_i(dq), .pins_o(pins), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .rd_invalid_o(rd_inv), .req_err_o(err), .mode_o(mode));
  srh_flash_model i_flash (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .pins_i(pins), .dq_o(dq), .busy_o(busy));

  // ==========================================================
  // Shared compare and closing
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One request: hold until taken, then wait for idle
  task automatic op(input srh_pkg::srh_op_t o, input logic [23:0] a, input logic [15:0] d,
                    input logic [17:0] x, input bit q);
    int k;
    if (q) expq.push_back(x);
    req_i <= '{o, a, d};
    req_valid_i <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (ready !== 1'b1 && k < 200);
    req_valid_i <= 1'b0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (ready !== 1'b1 && k < 400);
    chk(k < 400, "request hang");
  endtask

  // ==========================================================
  // Result monitor: oldest note against each result
  always @(posedge sys_clk_i) begin
    if (rd_valid === 1'b1 || err === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 18'h3FFFF;
      chk(err === e[17], "refusal mismatch");
      if (!e[17]) chk(rd_inv === e[16] && (e[16] || rd_data === e[15:0]), "read data mismatch");
    end
  end

  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(33760));
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    pa = 24'h8 + 24'($urandom % 120);
    pd = 16'($urandom);
    op(srh_pkg::SRH_OP_READ, 24'h10, 16'h0, {2'b00, 16'h3C2C}, 1);
    op(srh_pkg::SRH_OP_EXIT, 24'h0, 16'h0, 18'h20000, 1);
    op(srh_pkg::SRH_OP_ENTER, 24'h0, 16'h0, 18'h0, 0);
    chk(mode === 1'b1, "mode not entered");
    op(srh_pkg::SRH_OP_ENTER, 24'h0, 16'h0, 18'h20000, 1);
    $display("entry and refusals done");
    op(srh_pkg::SRH_OP_READ, 24'h3, 16'h0, {2'b00, 16'hE503}, 1);
    op(srh_pkg::SRH_OP_READ, 24'h80, 16'h0, 18'h10000, 1);
    op(srh_pkg::SRH_OP_READ, 24'h010020, 16'h0, {2'b00, 16'h3C1C}, 1);
    $display("remapped reads done");
    op(srh_pkg::SRH_OP_PROG, 24'h7, 16'h0, 18'h20000, 1);
    op(srh_pkg::SRH_OP_PROG, 24'h80, 16'h0, 18'h20000, 1);
    op(srh_pkg::SRH_OP_PROG, pa, pd, 18'h0, 0);
    op(srh_pkg::SRH_OP_READ, pa, 16'h0, 18'h20000, 1);
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    op(srh_pkg::SRH_OP_READ, pa, 16'h0, {2'b00, pd}, 1);
    op(srh_pkg::SRH_OP_EXIT, 24'h123, 16'h0, 18'h0, 0);
    chk(mode === 1'b0, "mode not left");
    op(srh_pkg::SRH_OP_READ, 24'h3, 16'h0, {2'b00, 16'h3C3F}, 1);
    $display("program and exit done");
    op(srh_pkg::SRH_OP_ENTER, 24'h0, 16'h0, 18'h0, 0);
    reset_i <= 1'b1;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    chk(mode === 1'b0, "mode kept over reset");
    op(srh_pkg::SRH_OP_READ, 24'h3, 16'h0, {2'b00, 16'h3C3F}, 1);
    repeat (30) @(posedge sys_clk_i);
    chk(expq.size() == 0, "results missing");
    $display("reset test done");
    end_of_test();
  end
endmodule
